// ==== rtl/cps_status.sv ====
// Status, interrupt and DMA-request logic of the CVSD/PCM converter.
// Assumes the converter core reports FIFO counts and access strobes
// synchronously to clk_i, and a classic Wishbone master.
`default_nettype none
module cps_status
(
	// Clock and reset
	input  wire  logic                      clk_i,
	input  wire  logic                      rst_i,
	// Wishbone slave
	input  wire  logic                      cyc_i,
	input  wire  logic                      stb_i,
	input  wire  logic                      we_i,
	input  wire  logic [cps_pkg::ADR_W-1:0] adr_i,
	input  wire  logic [3:0]                sel_i,
	input  wire  logic [31:0]               dat_i,
	output var   logic [31:0]               dat_o,
	output var   logic                      ack_o,
	// Converter core and debug
	input  wire  cps_pkg::cps_core_type     core_i,
	input  wire  logic                      freeze_i,
	input  wire  logic [cps_pkg::SMP_W-1:0] pcm_sample_i,
	output var   logic [cps_pkg::SMP_W-1:0] pcm_atten_o,
	// Interrupt and DMA
	output var   logic                      irq_o,
	output var   logic                      dma_out_req_o,
	output var   logic                      dma_in_req_o
);
	import cps_pkg::*;

	cps_state_type s;
	cps_state_type n;
	logic          req;
	logic          rd_stat;
	logic          wr_hit;
	logic [1:0]    idx;
	logic          ne_c;
	logic          nf_c;
	logic          pcm_c;
	logic          set_ne;
	logic          set_nf;
	logic          set_uf;
	logic          set_of;
	logic          set_pcm;
	logic [2:0]    in_fld;
	logic [2:0]    out_fld;
	logic [15:0]   stat_w;
	logic [IRQ_N-1:0] ev;

	//----------------------------------------------------------------
	// Next-state logic
	//----------------------------------------------------------------
	// One access per strobe; the ack flop blocks a second count of it.
	always_comb
	begin
		n       = s;
		req     = cyc_i & stb_i & ~s.ack;
		idx     = adr_i[3:2];
		rd_stat = req & ~we_i & (idx == IDX_STAT);
		wr_hit  = req & we_i & sel_i[0];
		n.ack   = req;
		// Level conditions from the core's counts and PCM levels.
		ne_c  = core_i.in_count <= NE_WORDS;
		nf_c  = core_i.out_count >= (FIFO_DEPTH - NF_FREE);
		pcm_c = core_i.pcm_full | core_i.pcm_empty;
		// Nearly-empty and nearly-full set on the edge of a condition so a read really clears; PCM service sets on the level.
		set_ne  = s.ctrl.enable & ne_c & ~s.prev_ne;
		set_nf  = s.ctrl.enable & nf_c & ~s.prev_nf;
		set_pcm = s.ctrl.enable & pcm_c;
		set_uf  = s.ctrl.enable & core_i.in_rd
			& (core_i.in_count == 4'h0);
		set_of  = s.ctrl.enable & core_i.out_wr
			& (core_i.out_count >= FIFO_DEPTH);
		n.prev_ne  = ne_c;
		n.prev_nf  = nf_c;
		n.prev_pcm = pcm_c;
		// Count fields saturate at seven words.
		if (core_i.in_count >= FLD_SAT)
			in_fld = 3'h0;
		else
			in_fld = 3'(FLD_SAT - core_i.in_count);
		if (core_i.out_count >= FLD_SAT)
			out_fld = 3'h7;
		else
			out_fld = core_i.out_count[2:0];
		stat_w = '0;
		if (s.ctrl.enable)
			stat_w = {5'h00, out_fld, in_fld, s.flags};
		// A read clears ne and nf, and pcm, uf and of outside freeze; a set in the same cycle wins.
		if (rd_stat)
		begin
			n.flags.ne = 1'b0;
			n.flags.nf = 1'b0;
			if (!freeze_i)
			begin
				n.flags.pcm = 1'b0;
				n.flags.uf  = 1'b0;
				n.flags.of  = 1'b0;
			end
		end
		n.flags.ne  = n.flags.ne | set_ne;
		n.flags.nf  = n.flags.nf | set_nf;
		n.flags.pcm = n.flags.pcm | set_pcm;
		n.flags.uf  = n.flags.uf | set_uf;
		n.flags.of  = n.flags.of | set_of;
		if (!s.ctrl.enable)
			n.flags = '0;
		// Register writes.
		if (wr_hit && idx == IDX_CTRL)
			n.ctrl = dat_i[7:0];
		if (wr_hit && idx == IDX_IRQ_MK)
			n.irq_mk = dat_i[IRQ_N-1:0];
		if (wr_hit && idx == IDX_IRQ_ST)
			n.irq_st = s.irq_st & ~dat_i[IRQ_N-1:0];
		// Interrupt events; set beats a same-cycle write-one-to-clear.
		ev          = '0;
		ev[IRQ_LVL] = s.ctrl.lvl_ie & (set_nf | set_ne);
		ev[IRQ_ERR] = s.ctrl.err_ie & (set_uf | set_of);
		ev[IRQ_PCM] = s.ctrl.pcm_ie & pcm_c & ~s.prev_pcm
			& s.ctrl.enable;
		n.irq_st = n.irq_st | ev;
		n.irq    = |(n.irq_st & n.irq_mk);
		// Read data; unmapped bits and lanes read as zero.
		n.dat = '0;
		if (req && !we_i)
		begin
			case (idx)
				IDX_CTRL:   n.dat = {24'h000000, s.ctrl};
				IDX_STAT:   n.dat = {16'h0000, stat_w};
				IDX_IRQ_ST: n.dat = {29'h0, s.irq_st};
				IDX_IRQ_MK: n.dat = {29'h0, s.irq_mk};
				default:    n.dat = '0;
			endcase
		end
		// Requests follow the flag so the request drops with a read.
		n.dma_out = n.ctrl.out_dma & n.flags.nf;
		n.dma_in  = n.ctrl.in_dma & n.flags.ne;
		// Shift is registered; the core sees it one cycle late.
		n.smp = SMP_W'($signed(pcm_sample_i) >>> s.ctrl.atten);
	end

	//----------------------------------------------------------------
	// State register
	//----------------------------------------------------------------
	// All state resets together to keep control and flags consistent.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s <= ST_RST;
		else
			s <= n;
	end

	assign dat_o         = s.dat;
	assign ack_o         = s.ack;
	assign irq_o         = s.irq;
	assign dma_out_req_o = s.dma_out;
	assign dma_in_req_o  = s.dma_in;
	assign pcm_atten_o   = s.smp;

	//----------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// A status read taken while the module is enabled.
	sequence s_stat_read;
		s.ctrl.enable && rd_stat;
	endsequence

	// A status read taken in debug freeze; error flags must survive it.
	sequence s_frozen_read;
		s_stat_read ##0 freeze_i;
	endsequence

	// A status read taken outside debug freeze.
	sequence s_plain_read;
		s_stat_read ##0 !freeze_i;
	endsequence

	a_nf_read_clr: assert property (s_stat_read ##0 !set_nf
		|=> !s.flags.nf)
		else $error("nearly-full not cleared by read");
	a_pcm_freeze: assert property (s_stat_read ##0 freeze_i
		##0 s.flags.pcm |=> s.flags.pcm)
		else $error("pcm flag lost in freeze");
	a_uf_set: assert property (s.ctrl.enable && core_i.in_rd
		&& core_i.in_count == 4'h0 |=> s.flags.uf)
		else $error("underflow not flagged");
	a_of_err_irq: assert property (set_of && s.ctrl.err_ie
		&& s.irq_mk[IRQ_ERR] |=> s.flags.of && irq_o)
		else $error("overflow error interrupt missing");
	a_nf_level_irq: assert property (set_nf && s.ctrl.lvl_ie
		&& s.irq_mk[IRQ_LVL] |=> irq_o[*2])
		else $error("nearly-full interrupt missing");
	a_ne_level_irq: assert property (set_ne && s.ctrl.lvl_ie
		|=> s.irq_st[IRQ_LVL])
		else $error("nearly-empty event missing");
	a_dma_out_req: assert property ($rose(s.flags.nf)
		&& s.ctrl.out_dma |-> dma_out_req_o)
		else $error("output dma request missing");
	a_disable_clr: assert property (!s.ctrl.enable
		|=> s.flags == '0)
		else $error("status not cleared while disabled");
	a_in_field: assert property (s_stat_read ##0
		core_i.in_count == 4'h0 |=> dat_o[7:5] == 3'h7)
		else $error("input free field wrong");
	a_out_field: assert property (s_stat_read ##0
		core_i.out_count == 4'h8 |=> dat_o[10:8] == 3'h7)
		else $error("output count field wrong");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held beyond one cycle");
	a_atten_shift: assert property (s.ctrl.atten == 2'h3
		&& !$changed(s.ctrl) |=> pcm_atten_o
		== 16'($signed($past(pcm_sample_i)) >>> 3))
		else $error("attenuation shift wrong");

	// A status read clears the input nearly-empty flag.
	a_ne_read_clr: assert property (s_stat_read ##0 !set_ne
		|=> !s.flags.ne)
		else $error("nearly-empty not cleared by read");

	// Outside freeze a read clears underflow unless it sets again.
	a_uf_read_clr: assert property (s_plain_read ##0 !set_uf
		|=> !s.flags.uf)
		else $error("underflow not cleared by read");

	// Outside freeze a read clears overflow unless it sets again.
	a_of_read_clr: assert property (s_plain_read ##0 !set_of
		|=> !s.flags.of)
		else $error("overflow not cleared by read");

	// In freeze the debugger may read without losing underflow.
	a_uf_freeze: assert property (s_frozen_read ##0 s.flags.uf
		|=> s.flags.uf)
		else $error("underflow lost in freeze");

	// In freeze the debugger may read without losing overflow.
	a_of_freeze: assert property (s_frozen_read ##0 s.flags.of
		|=> s.flags.of)
		else $error("overflow lost in freeze");

	// A converter write into a full output FIFO flags overflow.
	a_of_set: assert property (s.ctrl.enable && core_i.out_wr
		&& core_i.out_count >= FIFO_DEPTH |=> s.flags.of)
		else $error("overflow not flagged");

	// Three free slots left in the output FIFO sets nearly-full.
	a_nf_set: assert property (s.ctrl.enable && !s.prev_nf
		&& core_i.out_count == FIFO_DEPTH - NF_FREE |=> s.flags.nf)
		else $error("nearly-full not flagged");

	// Three words left in the input FIFO sets nearly-empty.
	a_ne_set: assert property (s.ctrl.enable && !s.prev_ne
		&& core_i.in_count == NE_WORDS |=> s.flags.ne)
		else $error("nearly-empty not flagged");

	// The input DMA request follows a fresh nearly-empty flag.
	a_ne_dma_req: assert property ($rose(s.flags.ne)
		&& s.ctrl.in_dma |-> dma_in_req_o)
		else $error("input dma request missing");

	// Either PCM condition keeps the service flag up.
	a_pcm_set: assert property (s.ctrl.enable
		&& (core_i.pcm_full || core_i.pcm_empty) |=> s.flags.pcm)
		else $error("pcm service not flagged");

	// A fresh PCM condition posts the PCM interrupt event.
	a_pcm_irq: assert property (s.ctrl.enable && s.ctrl.pcm_ie
		&& pcm_c && !s.prev_pcm |=> s.irq_st[IRQ_PCM])
		else $error("pcm interrupt event missing");

	// The interrupt line is the registered or of unmasked events.
	a_irq_level: assert property (irq_o == |(s.irq_st & s.irq_mk))
		else $error("interrupt line disagrees with status");

	// Read data is zero outside the acknowledge cycle.
	a_idle_data: assert property (!ack_o |-> dat_o == '0)
		else $error("read data not zero while idle");

	// A zero attenuation passes the sample unchanged.
	a_atten_none: assert property (s.ctrl.atten == 2'h0
		&& !$changed(s.ctrl) |=> pcm_atten_o == $past(pcm_sample_i))
		else $error("unshifted sample altered");

	// An empty output FIFO reads as no valid words.
	a_out_empty: assert property (s_stat_read ##0
		core_i.out_count == 4'h0 |=> dat_o[10:8] == 3'h0)
		else $error("output count field not zero");

	// Seven or eight input words leave no free slot reported.
	a_in_full: assert property (s_stat_read ##0
		core_i.in_count >= FLD_SAT |=> dat_o[7:5] == 3'h0)
		else $error("input free field not zero");

	// The status register is sixteen bits; the upper half reads zero.
	a_stat_upper: assert property (rd_stat
		|=> dat_o[31:16] == 16'h0000)
		else $error("status upper half not zero");

	// A disabled module reads an all-clear status.
	a_off_read: assert property (rd_stat && !s.ctrl.enable
		|=> dat_o[15:0] == 16'h0000)
		else $error("status not clear while disabled");
endmodule
`default_nettype wire

// ==== rtl/cps_pkg.sv ====
// Constants, register map and carrier types of the CVSD/PCM status block.
// Assumes a 32-bit classic Wishbone bus and an 8-word CVSD FIFO pair.
//
// Behaviour
// - Two-bit attenuation: 00 no shift, 01..11 shift by one to three; resets 0.
// - Attenuation is an arithmetic right shift, sign extended, of the sample.
// - Status is 16 bits read-only, cleared at reset and while module disabled.
// - Output nearly-full sets when just three free word slots remain.
// - Nearly-full raises the FIFO-level interrupt when its enable is set.
// - Nearly-full raises the output DMA request when output DMA is enabled.
// - A status read clears the output nearly-full flag.
// - PCM service sets when the result is waiting or the input is empty.
// - A status read clears PCM service, except during debug freeze.
// - Underflow sets on empty input read; error interrupt; read clears outside debug freeze.
// - Overflow sets on full output write; error interrupt; read clears outside debug freeze.
// - Input field gives free slots: 111b empty, 000b at seven or eight.
// - Output field gives word count: 000b empty, 111b at seven or eight.
// - Input nearly-empty also raises the FIFO-level interrupt when enabled.
`default_nettype none
package cps_pkg;
	//--------------------------------------------------------------
	// Register map, word indices on adr_i[3:2]
	//--------------------------------------------------------------
	localparam int unsigned ADR_W      = 4;
	localparam logic [1:0]  IDX_CTRL   = 2'h0;
	localparam logic [1:0]  IDX_STAT   = 2'h1;
	localparam logic [1:0]  IDX_IRQ_ST = 2'h2;
	localparam logic [1:0]  IDX_IRQ_MK = 2'h3;
	//--------------------------------------------------------------
	// FIFO levels and field codes
	//--------------------------------------------------------------
	localparam int unsigned CNT_W      = 4;
	localparam logic [3:0]  FIFO_DEPTH = 4'h8;
	localparam logic [3:0]  NF_FREE    = 4'h3;
	localparam logic [3:0]  NE_WORDS   = 4'h3;
	localparam logic [3:0]  FLD_SAT    = 4'h7;
	localparam int unsigned SMP_W      = 16;
	localparam int unsigned IRQ_N      = 3;
	localparam int unsigned IRQ_LVL    = 0;
	localparam int unsigned IRQ_ERR    = 1;
	localparam int unsigned IRQ_PCM    = 2;
	//--------------------------------------------------------------
	// Carrier types
	//--------------------------------------------------------------
	typedef struct packed {
		logic [1:0] atten;
		logic       in_dma;
		logic       out_dma;
		logic       err_ie;
		logic       lvl_ie;
		logic       pcm_ie;
		logic       enable;
	} cps_ctrl_type;
	typedef struct packed {
		logic of;
		logic uf;
		logic pcm;
		logic nf;
		logic ne;
	} cps_flag_type;
	typedef struct packed {
		logic [3:0] in_count;
		logic [3:0] out_count;
		logic       in_rd;
		logic       out_wr;
		logic       pcm_full;
		logic       pcm_empty;
	} cps_core_type;
	typedef struct packed {
		cps_ctrl_type           ctrl;
		cps_flag_type           flags;
		logic                   prev_ne;
		logic                   prev_nf;
		logic                   prev_pcm;
		logic [IRQ_N-1:0]       irq_st;
		logic [IRQ_N-1:0]       irq_mk;
		logic                   irq;
		logic                   ack;
		logic [31:0]            dat;
		logic                   dma_out;
		logic                   dma_in;
		logic [SMP_W-1:0]       smp;
	} cps_state_type;
	localparam cps_state_type ST_RST = '0;
endpackage
`default_nettype wire

// ==== test/cps_core_model.sv ====
// Converter core model: FIFO fill levels, access strobes and PCM levels.
// Assumes one-cycle requests driven just after clk_i rises.
`default_nettype none
module cps_core_model
(
	// Clock, reset and requests: [0] write out, [1] read in, [2] fill in
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic [2:0]            act_i,
	input  wire logic [1:0]            pcm_i,
	// Towards the status block
	output var  cps_pkg::cps_core_type core_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import cps_pkg::*;
	logic [3:0] in_ff;
	logic [3:0] out_ff;
	// Levels move at the edge; strobes pass straight on, so each strobe is
	// seen with the level before it, as a real FIFO would report it.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			in_ff <= 4'h0;
			out_ff <= 4'h0;
		end
		else
		begin
			if (act_i[0] && out_ff != FIFO_DEPTH)
				out_ff <= out_ff + 4'h1;
			if (act_i[2] && in_ff != FIFO_DEPTH)
				in_ff <= in_ff + 4'h1;
			else if (act_i[1] && in_ff != 4'h0)
				in_ff <= in_ff - 4'h1;
		end
	end
	// PCM levels pass through: result waiting, then input empty.
	always_comb
		core_o = {in_ff, out_ff, act_i[1], act_i[0], pcm_i};
endmodule
`default_nettype wire

// ==== test/test_cvsd_pcm_status_flags.sv ====
// Bench of the CVSD/PCM status block: Wishbone tasks and flag scenarios.
// Assumes cps_status and the core model cps_core_model.
`default_nettype none
module test_cvsd_pcm_status_flags;
	timeunit 1ns;
	timeprecision 1ps;
	import cps_pkg::*;
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic         cyc = 1'b0, stb = 1'b0, we = 1'b0, frz = 1'b0;
	logic [3:0]   adr = 4'h0, sel = 4'h0;
	logic [2:0]   act = 3'h0;
	logic [1:0]   pcm = 2'h0;
	logic [31:0]  dat = 32'h0, rdat, q;
	logic [15:0]  smp = 16'hF0F0, att, exp_att;
	logic         ack, irq, dma_o, dma_i;
	cps_core_type core;
	int           n_mismatch = 0, n_compared = 0, cycles = 0;
	// Free-running clock, 10 ns period.
	always #5 clk_i = ~clk_i;
	cps_core_model u_core
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.act_i (act),
		.pcm_i (pcm),
		.core_o(core)
	);
	cps_status u_dut
	(
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.cyc_i        (cyc),
		.stb_i        (stb),
		.we_i         (we),
		.adr_i        (adr),
		.sel_i        (sel),
		.dat_i        (dat),
		.dat_o        (rdat),
		.ack_o        (ack),
		.core_i       (core),
		.freeze_i     (frz),
		.pcm_sample_i (smp),
		.pcm_atten_o  (att),
		.irq_o        (irq),
		.dma_out_req_o(dma_o),
		.dma_in_req_o (dma_i)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic results();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One classic cycle; a hung slave is cut short by the cycle ceiling.
	task automatic wb(input logic w, input logic [3:0] a, s,
		input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 4'hF, 32'h0);
		chk(q, e);
	endtask
	// Strobes the core model n times with an idle cycle in between.
	task automatic pulse(input logic [2:0] m, input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			act <= m;
			@(posedge clk_i);
			act <= 3'h0;
		end
	endtask
	// Interrupt and both DMA requests, after the flags have settled.
	task automatic lines(input logic [2:0] e);
		repeat (2) @(posedge clk_i);
		chk(32'({irq, dma_o, dma_i}), 32'(e));
	endtask
	// Ceiling well above the few hundred cycles the run needs.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			results();
		end
	end
	// Status layout: ne, nf, pcm, uf, of, free[7:5], words[10:8].
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(4'h0, 32'h0);
		rd(4'h4, 32'h0);
		pulse(3'b100, 8);
		pulse(3'b001, 4);
		rd(4'h4, 32'h0);
		wb(1'b1, 4'h0, 4'hF, 32'h3D);
		wb(1'b1, 4'hC, 4'hF, 32'h3);
		rd(4'h4, 32'h400);
		pulse(3'b001, 1);
		lines(3'b110);
		rd(4'h4, 32'h502);
		rd(4'h4, 32'h500);
		rd(4'h8, 32'h1);
		wb(1'b1, 4'h8, 4'hF, 32'h1);
		lines(3'b000);
		pulse(3'b001, 4);
		lines(3'b100);
		rd(4'h4, 32'h710);
		rd(4'h4, 32'h700);
		wb(1'b1, 4'h8, 4'hF, 32'h2);
		frz <= 1'b1;
		pcm <= 2'b10;
		pulse(3'b001, 1);
		pcm <= 2'b00;
		rd(4'h4, 32'h714);
		rd(4'h4, 32'h714);
		frz <= 1'b0;
		rd(4'h4, 32'h714);
		rd(4'h4, 32'h700);
		wb(1'b1, 4'h8, 4'hF, 32'h2);
		pulse(3'b010, 4);
		rd(4'h4, 32'h760);
		pulse(3'b010, 1);
		lines(3'b101);
		rd(4'h4, 32'h781);
		rd(4'h4, 32'h780);
		wb(1'b1, 4'h8, 4'hF, 32'h1);
		pulse(3'b010, 4);
		lines(3'b100);
		rd(4'h4, 32'h7E8);
		rd(4'h4, 32'h7E0);
		// PCM interrupt path: input register empty with its enable on.
		wb(1'b1, 4'h8, 4'hF, 32'h2);
		wb(1'b1, 4'h0, 4'hF, 32'h3F);
		wb(1'b1, 4'hC, 4'hF, 32'h4);
		pcm <= 2'b01;
		lines(3'b100);
		pcm <= 2'b00;
		rd(4'h8, 32'h4);
		rd(4'h4, 32'h7E4);
		rd(4'h4, 32'h7E0);
		// Each shift step halves the sample and keeps its sign bit.
		exp_att = 16'hF0F0;
		for (int a = 0; a < 4; a++)
		begin
			wb(1'b1, 4'h0, 4'hF, 32'h3D | (32'(a) << 6));
			repeat (2) @(posedge clk_i);
			chk(32'(att), 32'(exp_att));
			exp_att = {exp_att[15], exp_att[15:1]};
		end
		rd(4'h0, 32'hFD);
		wb(1'b1, 4'h0, 4'hE, 32'h0);
		rd(4'h0, 32'hFD);
		wb(1'b1, 4'h0, 4'hF, 32'h0);
		rd(4'h4, 32'h0);
		results();
	end
endmodule
`default_nettype wire
